// file: rtl/rtlf_pkg.sv
// Shared constants, carrier types and frame field packing for the target list framer
package rtlf_pkg;

   // Frame identifiers
   localparam logic [10:0] RTLF_ID_HEADER  = 11'h600;
   localparam logic [10:0] RTLF_ID_GENERAL = 11'h701;
   localparam logic [10:0] RTLF_ID_QUALITY = 11'h702;

   // List limits
   localparam logic [8:0] RTLF_MAX_SENT   = 9'h0fa;
   localparam int         RTLF_MEM_DEPTH  = 256;
   localparam logic [8:0] RTLF_MEM_FULL   = 9'h100;
   localparam logic [3:0] RTLF_FORMAT_VER = 4'h1;
   localparam logic [8:0] RTLF_VLAT_ZERO  = 9'h100;

   // Field start bits and lengths, start bit is the field's least significant bit
   localparam int RTLF_POS_NEAR = 0;
   localparam int RTLF_LEN_NEAR = 8;
   localparam int RTLF_POS_FAR  = 8;
   localparam int RTLF_LEN_FAR  = 8;
   localparam int RTLF_POS_CNT  = 24;
   localparam int RTLF_LEN_CNT  = 16;
   localparam int RTLF_POS_VER  = 36;
   localparam int RTLF_LEN_VER  = 4;
   localparam int RTLF_POS_IDX  = 0;
   localparam int RTLF_LEN_IDX  = 8;
   localparam int RTLF_POS_DLON = 19;
   localparam int RTLF_LEN_DLON = 13;
   localparam int RTLF_POS_DLAT = 24;
   localparam int RTLF_LEN_DLAT = 10;
   localparam int RTLF_POS_VLON = 46;
   localparam int RTLF_LEN_VLON = 10;
   localparam int RTLF_POS_MOT  = 48;
   localparam int RTLF_LEN_MOT  = 3;
   localparam int RTLF_POS_VLAT = 53;
   localparam int RTLF_LEN_VLAT = 9;
   localparam int RTLF_POS_RCS  = 56;
   localparam int RTLF_LEN_RCS  = 8;
   localparam int RTLF_POS_DLRM = 11;
   localparam int RTLF_POS_VLRM = 17;
   localparam int RTLF_POS_DTRM = 22;
   localparam int RTLF_POS_PDH  = 24;
   localparam int RTLF_POS_VTRM = 28;
   localparam int RTLF_POS_AMB  = 32;
   localparam int RTLF_POS_INV  = 35;
   localparam int RTLF_LEN_RMS  = 5;
   localparam int RTLF_LEN_Q3   = 3;

   // Timing: list repeat interval
   localparam int RTLF_INTERVAL_MS   = 75;
   localparam int RTLF_CLK_KHZ       = 200000;
   localparam int RTLF_INTERVAL_CYC  = RTLF_INTERVAL_MS * RTLF_CLK_KHZ;

   // Register map (byte addresses) and control bits
   localparam logic [7:0]  RTLF_ADR_CTRL   = 8'h00;
   localparam logic [7:0]  RTLF_ADR_STATUS = 8'h04;
   localparam logic [7:0]  RTLF_ADR_COUNTS = 8'h08;
   localparam int          RTLF_CTRL_LIST  = 0;
   localparam int          RTLF_CTRL_QUAL  = 1;
   localparam logic [1:0]  RTLF_CTRL_RST   = 2'h1;
   localparam int          RTLF_STAT_BUSY  = 16;

   typedef struct packed {
      logic        far_scan;
      logic [12:0] longitudinal_distance;
      logic [9:0]  lateral_distance;
      logic [9:0]  longitudinal_rel_velocity;
      logic [2:0]  motion_class;
      logic [7:0]  reflectivity;
      logic [4:0]  dist_long_rms;
      logic [4:0]  vel_long_rms;
      logic [4:0]  dist_lat_rms;
      logic [2:0]  false_alarm;
      logic [4:0]  vel_lat_rms;
      logic [2:0]  ambiguity;
      logic [4:0]  validity;
   } rtlf_item_t;

   typedef struct packed {
      logic [10:0] id;
      logic [63:0] data;
   } rtlf_frame_t;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } rtlf_wb_req_t;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } rtlf_wb_rsp_t;

   // Places a field: bits rise within a byte, then continue at bit 0 of the preceding byte
   function automatic logic [63:0] rtlf_put_field(input logic [63:0] frame, input int start,
                                                  input int len, input logic [15:0] val);
      logic [63:0] f;
      int          b;
      f = frame;
      b = start;
      for (int i = 0; i < 16; i++) begin
         if (i < len) begin
            f[b[5:0]] = val[i];
            b = (b % 8 == 7) ? b - 15 : b + 1;
         end
      end
      return f;
   endfunction : rtlf_put_field

endpackage : rtlf_pkg

// file: rtl/rtlf_cycle_timer.sv
// Measurement cycle interval timer and wrapping cycle counter
`timescale 1ns/1ps
module rtlf_cycle_timer #(
   parameter int P_INTERVAL_CYC = rtlf_pkg::RTLF_INTERVAL_CYC
) (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   output logic             o_tick,
   output logic [15:0]      o_cycle_counter
);
   import rtlf_pkg::*;

   logic [31:0] div_q;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         div_q  <= 32'h0;
         o_tick <= 1'b0;
      end else if (div_q == 32'(P_INTERVAL_CYC - 1)) begin
         div_q  <= 32'h0;
         o_tick <= 1'b1;
      end else begin
         div_q  <= div_q + 32'h1;
         o_tick <= 1'b0;
      end
   end

   // Counts from startup and rolls over to zero past the top value
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_cycle_counter <= 16'h0;
      end else if (o_tick) begin
         o_cycle_counter <= o_cycle_counter + 16'h1;
      end
   end

endmodule : rtlf_cycle_timer

// file: rtl/rtlf_wb_regs.sv
// Classic Wishbone register slave: control, status and count registers
`timescale 1ns/1ps
module rtlf_wb_regs (
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   input  wire rtlf_pkg::rtlf_wb_req_t i_wb,
   output rtlf_pkg::rtlf_wb_rsp_t      o_wb,
   output logic                       o_list_en,
   output logic                       o_quality_en,
   input  wire logic [15:0]           i_cycle_counter,
   input  wire logic                  i_busy,
   input  wire logic [15:0]           i_last_counts,
   input  wire logic [8:0]            i_stored
);
   import rtlf_pkg::*;

   logic req;
   assign req = i_wb.cyc & i_wb.stb & ~o_wb.ack;

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_list_en    <= RTLF_CTRL_RST[RTLF_CTRL_LIST];
         o_quality_en <= RTLF_CTRL_RST[RTLF_CTRL_QUAL];
      end else if (req && i_wb.we && i_wb.sel[0] && i_wb.adr == RTLF_ADR_CTRL) begin
         o_list_en    <= i_wb.dat[RTLF_CTRL_LIST];
         o_quality_en <= i_wb.dat[RTLF_CTRL_QUAL];
      end
   end

   // One wait state; unmapped addresses still answer, reading zero
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_wb <= '0;
      end else begin
         o_wb.ack <= req;
         o_wb.dat <= 32'h0;
         if (req && !i_wb.we) begin
            case (i_wb.adr)
               RTLF_ADR_CTRL:   o_wb.dat <= {30'h0, o_quality_en, o_list_en};
               RTLF_ADR_STATUS: o_wb.dat <= {15'h0, i_busy, i_cycle_counter};
               RTLF_ADR_COUNTS: o_wb.dat <= {7'h0, i_stored, i_last_counts};
               default:         o_wb.dat <= 32'h0;
            endcase
         end
      end
   end

endmodule : rtlf_wb_regs

// file: rtl/rtlf_framer.sv
// Target list framer: collects detections each measurement cycle and emits the framed list
//
// What this block does
// - Exactly one header frame per list, always the list's first frame.
// - Header carries near item count, unsigned 8 bits at bit 0.
// - Header carries far item count at bit 8; entry variant always sends zero.
// - Near plus far count reported and sent never exceeds 250.
// - Header carries 16-bit cycle counter at bit 24, counting up, wrapping.
// - Header carries 4-bit list format version at bit 36.
// - One general frame per item after header, near items before far items.
// - Near and far lists are each sent in ascending range order.
// - Beyond 250 items, only the first 250 in list order are sent.
// - General frame holds 13-bit longitudinal and 10-bit lateral distance codes.
// - General frame holds 10-bit longitudinal relative velocity at bit 46.
// - General frame holds 3-bit motion class at bit 48.
// - Lateral relative velocity field at bit 53 always carries the zero code.
// - Quality frames are sent only while quality output is enabled.
// - One quality frame per item, same items and order as general frames.
// - List repeats every measurement interval, only while list output is selected.
// - All general frames of a cycle precede the first quality frame.
`timescale 1ns/1ps
module rtlf_framer #(
   parameter int P_INTERVAL_CYC = rtlf_pkg::RTLF_INTERVAL_CYC,
   parameter bit P_FAR_SCAN     = 1'b1
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   input  wire rtlf_pkg::rtlf_wb_req_t i_wb,
   output rtlf_pkg::rtlf_wb_rsp_t      o_wb,
   input  wire logic                   i_det_valid,
   input  wire rtlf_pkg::rtlf_item_t   i_det,
   output logic                        o_det_ready,
   output logic                        o_frame_valid,
   output rtlf_pkg::rtlf_frame_t       o_frame,
   input  wire logic                   i_frame_ready
);
   import rtlf_pkg::*;

   typedef enum logic [2:0] {
      RTLF_IDLE = 3'b000,
      RTLF_HDR  = 3'b001,
      RTLF_SCAN = 3'b011,
      RTLF_GEN  = 3'b010,
      RTLF_QUAL = 3'b110,
      RTLF_DONE = 3'b111
   } rtlf_state_t;

   rtlf_state_t state_q;
   rtlf_item_t  item_mem [RTLF_MEM_DEPTH];
   logic [7:0]  order_mem [RTLF_MEM_DEPTH];

   logic        tick;
   logic [15:0] cycle_counter;
   logic        list_en;
   logic        quality_en;
   logic        busy;

   logic [8:0]  stored_q;
   logic [8:0]  near_raw_q;
   logic [8:0]  far_raw_q;
   logic [7:0]  near_rep_q;
   logic [7:0]  far_rep_q;
   logic [8:0]  total_q;
   logic [15:0] hdr_counter_q;
   logic        qual_q;
   logic [255:0] sent_q;
   logic [7:0]  scan_ptr_q;
   logic [7:0]  best_q;
   logic [12:0] best_key_q;
   logic        found_q;
   logic [8:0]  slot_q;
   logic [15:0] last_counts_q;

   logic        accept;
   logic        handshake;
   logic        phase_far;
   logic        scan_last;
   logic        candidate;
   logic [8:0]  near_cap;
   logic [8:0]  far_cap;
   rtlf_item_t  scan_item;
   rtlf_item_t  pick_item;

   rtlf_cycle_timer #(
      .P_INTERVAL_CYC (P_INTERVAL_CYC)
   ) u_timer (
      .i_clk           (i_clk),
      .i_rst_n         (i_rst_n),
      .o_tick          (tick),
      .o_cycle_counter (cycle_counter)
   );

   rtlf_wb_regs u_regs (
      .i_clk           (i_clk),
      .i_rst_n         (i_rst_n),
      .i_wb            (i_wb),
      .o_wb            (o_wb),
      .o_list_en       (list_en),
      .o_quality_en    (quality_en),
      .i_cycle_counter (cycle_counter),
      .i_busy          (busy),
      .i_last_counts   (last_counts_q),
      .i_stored        (stored_q)
   );

   function automatic logic [8:0] min9(input logic [8:0] a, input logic [8:0] b);
      return (a < b) ? a : b;
   endfunction : min9

   // Detections are taken only between lists, so the stored set cannot move while framing
   assign busy        = (state_q != RTLF_IDLE);
   assign o_det_ready = ~busy & ~tick;
   assign accept      = i_det_valid & o_det_ready;
   assign handshake   = o_frame_valid & i_frame_ready;

   // Header counts are clipped so near plus far never passes the send limit
   assign near_cap  = min9(near_raw_q, RTLF_MAX_SENT);
   assign far_cap   = P_FAR_SCAN ? min9(far_raw_q, RTLF_MAX_SENT - near_cap) : 9'h0;

   assign scan_item = item_mem[scan_ptr_q];
   assign pick_item = (state_q == RTLF_QUAL) ? item_mem[order_mem[slot_q[7:0]]] : item_mem[best_q];
   assign phase_far = (slot_q >= {1'b0, near_rep_q});
   assign scan_last = ({1'b0, scan_ptr_q} == stored_q - 9'h1);
   assign candidate = ~sent_q[scan_ptr_q] & (scan_item.far_scan == phase_far) &
                      (~found_q | (scan_item.longitudinal_distance < best_key_q));

   // Detection store
   always_ff @(posedge i_clk) begin
      if (accept && stored_q != RTLF_MEM_FULL && (P_FAR_SCAN || !i_det.far_scan)) begin
         item_mem[stored_q[7:0]] <= i_det;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         stored_q   <= 9'h0;
         near_raw_q <= 9'h0;
         far_raw_q  <= 9'h0;
      end else if (state_q == RTLF_DONE || (tick && !busy && !list_en)) begin
         // A cycle's items are consumed or discarded once its interval ends
         stored_q   <= 9'h0;
         near_raw_q <= 9'h0;
         far_raw_q  <= 9'h0;
      end else if (accept && stored_q != RTLF_MEM_FULL && (P_FAR_SCAN || !i_det.far_scan)) begin
         stored_q <= stored_q + 9'h1;
         if (i_det.far_scan) begin
            far_raw_q <= far_raw_q + 9'h1;
         end else begin
            near_raw_q <= near_raw_q + 9'h1;
         end
      end
   end

   // Per-list snapshot taken when the list starts
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         near_rep_q    <= 8'h0;
         far_rep_q     <= 8'h0;
         total_q       <= 9'h0;
         hdr_counter_q <= 16'h0;
         qual_q        <= 1'b0;
         last_counts_q <= 16'h0;
      end else if (state_q == RTLF_IDLE && tick && list_en) begin
         near_rep_q    <= near_cap[7:0];
         far_rep_q     <= far_cap[7:0];
         total_q       <= near_cap + far_cap;
         hdr_counter_q <= cycle_counter;
         qual_q        <= quality_en;
         last_counts_q <= {far_cap[7:0], near_cap[7:0]};
      end
   end

   // List sequencer
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= RTLF_IDLE;
      end else begin
         case (state_q)
            RTLF_IDLE: begin
               if (tick && list_en) begin
                  state_q <= RTLF_HDR;
               end
            end
            RTLF_HDR: begin
               if (handshake) begin
                  state_q <= (total_q == 9'h0) ? RTLF_DONE : RTLF_SCAN;
               end
            end
            RTLF_SCAN: begin
               if (scan_last) begin
                  state_q <= RTLF_GEN;
               end
            end
            RTLF_GEN: begin
               if (handshake) begin
                  if (slot_q + 9'h1 != total_q) begin
                     state_q <= RTLF_SCAN;
                  end else if (qual_q) begin
                     state_q <= RTLF_QUAL;
                  end else begin
                     state_q <= RTLF_DONE;
                  end
               end
            end
            RTLF_QUAL: begin
               if (handshake && slot_q + 9'h1 == total_q) begin
                  state_q <= RTLF_DONE;
               end
            end
            RTLF_DONE: state_q <= RTLF_IDLE;
            default:   state_q <= RTLF_IDLE;
         endcase
      end
   end

   // Minimum search: one stored item per cycle, earliest wins a tie
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         scan_ptr_q <= 8'h0;
         best_q     <= 8'h0;
         best_key_q <= 13'h0;
         found_q    <= 1'b0;
      end else if (state_q == RTLF_SCAN) begin
         scan_ptr_q <= scan_last ? 8'h0 : scan_ptr_q + 8'h1;
         if (candidate) begin
            best_q     <= scan_ptr_q;
            best_key_q <= scan_item.longitudinal_distance;
            found_q    <= 1'b1;
         end
      end else begin
         scan_ptr_q <= 8'h0;
         found_q    <= 1'b0;
      end
   end

   // Sent marks and output slot; the slot becomes the item index
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sent_q <= '0;
         slot_q <= 9'h0;
      end else begin
         case (state_q)
            RTLF_GEN: begin
               if (handshake) begin
                  sent_q[best_q] <= 1'b1;
                  slot_q         <= (slot_q + 9'h1 == total_q) ? 9'h0 : slot_q + 9'h1;
               end
            end
            RTLF_QUAL: begin
               if (handshake) begin
                  slot_q <= slot_q + 9'h1;
               end
            end
            RTLF_DONE: begin
               sent_q <= '0;
               slot_q <= 9'h0;
            end
            default: begin
               slot_q <= slot_q;
            end
         endcase
      end
   end

   // Remembers the general frame order so the quality pass replays it
   always_ff @(posedge i_clk) begin
      if (state_q == RTLF_GEN && handshake) begin
         order_mem[slot_q[7:0]] <= best_q;
      end
   end

   // Frame builder; the frame register loads as each frame is offered
   function automatic logic [63:0] hdr_frame(input logic [7:0] near, input logic [7:0] far,
                                             input logic [15:0] cnt);
      logic [63:0] f;
      f = 64'h0;
      f = rtlf_put_field(f, RTLF_POS_NEAR, RTLF_LEN_NEAR, {8'h0, near});
      f = rtlf_put_field(f, RTLF_POS_FAR, RTLF_LEN_FAR, {8'h0, far});
      f = rtlf_put_field(f, RTLF_POS_CNT, RTLF_LEN_CNT, cnt);
      f = rtlf_put_field(f, RTLF_POS_VER, RTLF_LEN_VER, {12'h0, RTLF_FORMAT_VER});
      return f;
   endfunction : hdr_frame

   function automatic logic [63:0] gen_frame(input logic [7:0] idx, input rtlf_item_t it);
      logic [63:0] f;
      f = 64'h0;
      f = rtlf_put_field(f, RTLF_POS_IDX, RTLF_LEN_IDX, {8'h0, idx});
      f = rtlf_put_field(f, RTLF_POS_DLON, RTLF_LEN_DLON, {3'h0, it.longitudinal_distance});
      f = rtlf_put_field(f, RTLF_POS_DLAT, RTLF_LEN_DLAT, {6'h0, it.lateral_distance});
      f = rtlf_put_field(f, RTLF_POS_VLON, RTLF_LEN_VLON, {6'h0, it.longitudinal_rel_velocity});
      f = rtlf_put_field(f, RTLF_POS_MOT, RTLF_LEN_MOT, {13'h0, it.motion_class});
      f = rtlf_put_field(f, RTLF_POS_VLAT, RTLF_LEN_VLAT, {7'h0, RTLF_VLAT_ZERO});
      f = rtlf_put_field(f, RTLF_POS_RCS, RTLF_LEN_RCS, {8'h0, it.reflectivity});
      return f;
   endfunction : gen_frame

   function automatic logic [63:0] qual_frame(input logic [7:0] idx, input rtlf_item_t it);
      logic [63:0] f;
      f = 64'h0;
      f = rtlf_put_field(f, RTLF_POS_IDX, RTLF_LEN_IDX, {8'h0, idx});
      f = rtlf_put_field(f, RTLF_POS_DLRM, RTLF_LEN_RMS, {11'h0, it.dist_long_rms});
      f = rtlf_put_field(f, RTLF_POS_VLRM, RTLF_LEN_RMS, {11'h0, it.vel_long_rms});
      f = rtlf_put_field(f, RTLF_POS_DTRM, RTLF_LEN_RMS, {11'h0, it.dist_lat_rms});
      f = rtlf_put_field(f, RTLF_POS_PDH, RTLF_LEN_Q3, {13'h0, it.false_alarm});
      f = rtlf_put_field(f, RTLF_POS_VTRM, RTLF_LEN_RMS, {11'h0, it.vel_lat_rms});
      f = rtlf_put_field(f, RTLF_POS_AMB, RTLF_LEN_Q3, {13'h0, it.ambiguity});
      f = rtlf_put_field(f, RTLF_POS_INV, RTLF_LEN_RMS, {11'h0, it.validity});
      return f;
   endfunction : qual_frame

   // The header is offered first in every list, before any item frame
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_frame_valid <= 1'b0;
         o_frame       <= '0;
      end else if (state_q == RTLF_IDLE && tick && list_en) begin
         o_frame_valid <= 1'b1;
         o_frame.id    <= RTLF_ID_HEADER;
         o_frame.data  <= hdr_frame(near_cap[7:0], far_cap[7:0], cycle_counter);
      end else if (state_q == RTLF_SCAN && scan_last) begin
         o_frame_valid <= 1'b1;
         o_frame.id    <= RTLF_ID_GENERAL;
         o_frame.data  <= gen_frame(slot_q[7:0], candidate ? scan_item : item_mem[best_q]);
      end else if (state_q == RTLF_GEN && handshake && slot_q + 9'h1 == total_q && qual_q) begin
         o_frame_valid <= 1'b1;
         o_frame.id    <= RTLF_ID_QUALITY;
         o_frame.data  <= qual_frame(8'h0, item_mem[(slot_q == 9'h0) ? best_q : order_mem[8'h0]]);
      end else if (state_q == RTLF_QUAL && handshake && slot_q + 9'h1 != total_q) begin
         o_frame_valid <= 1'b1;
         o_frame.data  <= qual_frame(slot_q[7:0] + 8'h1, item_mem[order_mem[slot_q[7:0] + 8'h1]]);
      end else if (handshake) begin
         o_frame_valid <= 1'b0;
      end
   end

   logic unused_pick;
   assign unused_pick = ^pick_item;

endmodule : rtlf_framer

// file: bench/rtlf_framer_assertions.sv
// Checker for frame order, fixed fields and register bus handshake of the framer
`timescale 1ns/1ps
module rtlf_framer_assertions #(
   parameter int P_INTERVAL_CYC = 2000,
   parameter bit P_FAR_SCAN     = 1'b1
) (
   input  wire logic                   i_clk,
   input  wire logic                   i_rst_n,
   input  wire rtlf_pkg::rtlf_wb_req_t i_wb,
   input  wire rtlf_pkg::rtlf_wb_rsp_t o_wb,
   input  wire logic                   o_det_ready,
   input  wire logic                   o_frame_valid,
   input  wire rtlf_pkg::rtlf_frame_t  o_frame,
   input  wire logic                   i_frame_ready
);
   import rtlf_pkg::*;
   logic       hdr_v, gen_v, qual_v, qual_seen_q;
   logic [7:0] gen_idx_q;
   assign hdr_v  = o_frame_valid && o_frame.id == RTLF_ID_HEADER;
   assign gen_v  = o_frame_valid && o_frame.id == RTLF_ID_GENERAL;
   assign qual_v = o_frame_valid && o_frame.id == RTLF_ID_QUALITY;
   // Item index and quality phase restart with every header
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         qual_seen_q <= 1'b0;
         gen_idx_q   <= 8'h00;
      end else if (i_frame_ready && hdr_v) begin
         qual_seen_q <= 1'b0;
         gen_idx_q   <= 8'h00;
      end else if (i_frame_ready) begin
         qual_seen_q <= qual_seen_q | qual_v;
         gen_idx_q   <= gen_idx_q + {7'h00, gen_v};
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   property p_hold; o_frame_valid && !i_frame_ready |=> o_frame_valid && $stable(o_frame); endproperty
   a_hold: assert property (p_hold) else $error("frame changed before taken");
   property p_ack_resp; i_wb.cyc && i_wb.stb && !o_wb.ack |=> o_wb.ack; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("bus request not acknowledged");
   property p_ack_one; o_wb.ack |=> !o_wb.ack; endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
   property p_busy; o_frame_valid |-> !o_det_ready; endproperty
   a_busy: assert property (p_busy) else $error("detections accepted during list");
   property p_vlat; gen_v |-> o_frame.data[55:53] == 3'h0 && o_frame.data[45:40] == 6'h20; endproperty
   a_vlat: assert property (p_vlat) else $error("lateral velocity not zero code");
   property p_ver; hdr_v |-> o_frame.data[39:36] == RTLF_FORMAT_VER; endproperty
   a_ver: assert property (p_ver) else $error("wrong format version");
   property p_sum; hdr_v |-> {1'b0, o_frame.data[7:0]} + {1'b0, o_frame.data[15:8]} <= RTLF_MAX_SENT; endproperty
   a_sum: assert property (p_sum) else $error("item count above limit");
   property p_order; gen_v |-> !qual_seen_q; endproperty
   a_order: assert property (p_order) else $error("general frame after quality frame");
   property p_idx; gen_v |-> o_frame.data[7:0] == gen_idx_q; endproperty
   a_idx: assert property (p_idx) else $error("item index out of sequence");
endmodule : rtlf_framer_assertions
bind rtlf_framer rtlf_framer_assertions #(.P_INTERVAL_CYC(P_INTERVAL_CYC), .P_FAR_SCAN(P_FAR_SCAN)) u_chk (
   .i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb(i_wb), .o_wb(o_wb), .o_det_ready(o_det_ready),
   .o_frame_valid(o_frame_valid), .o_frame(o_frame), .i_frame_ready(i_frame_ready));

// file: bench/rtlf_sink_model.sv
// Host side frame sink: takes frames at once or with pseudo-random stalls
`timescale 1ns/1ps
module rtlf_sink_model (
   input  wire logic i_clk,
   input  wire logic i_rst_n,
   input  wire logic i_slow,
   output logic      o_ready
);
   logic [7:0] lfsr_q;
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         lfsr_q  <= 8'h5a;
         o_ready <= 1'b0;
      end else begin
         lfsr_q  <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
         o_ready <= !i_slow || lfsr_q[1:0] == 2'h0;
      end
   end
endmodule : rtlf_sink_model

// file: bench/testbench.sv
// Self-checking bench for the target list framer
`timescale 1ns/1ps
module testbench;
   import rtlf_pkg::*;
   localparam int P_INT = 2000;
   logic         i_clk, i_rst_n, i_det_valid, i_frame_ready, o_det_ready, o_frame_valid, slow;
   rtlf_wb_req_t i_wb;
   rtlf_wb_rsp_t o_wb;
   rtlf_item_t   i_det, near_q[$], far_q[$];
   rtlf_frame_t  o_frame;
   logic [74:0]  exp_q[$];
   logic [31:0]  seed = 32'h871c3c38;
   int           errors = 0, n_tests = 0;
   rtlf_framer #(.P_INTERVAL_CYC(P_INT), .P_FAR_SCAN(1'b1)) DUT (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb(i_wb),
      .o_wb(o_wb), .i_det_valid(i_det_valid), .i_det(i_det), .o_det_ready(o_det_ready),
      .o_frame_valid(o_frame_valid), .o_frame(o_frame), .i_frame_ready(i_frame_ready));
   rtlf_sink_model u_sink (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_slow(slow), .o_ready(i_frame_ready));
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   // Reassembles fields that run on into the preceding byte
   function automatic logic [63:0] dec(input rtlf_frame_t f);
      logic [63:0] d;
      d = f.data;
      if (f.id == RTLF_ID_HEADER) return {28'h0, d[7:0], d[15:8], d[23:16], d[31:24], d[39:36]};
      if (f.id == RTLF_ID_GENERAL) return {3'h0, d[7:0], d[15:8], d[23:19], d[17:16], d[31:24], d[39:32],
         d[47:46], d[50:48], d[45:40], d[55:53], d[63:56]};
      return {51'h0, d[7:0], d[15:11]};
   endfunction : dec
   task automatic chk(input string nm, input logic [74:0] e, input logic [74:0] s);
      n_tests++;
      if (s !== e) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic rd(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
      i_wb <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'hf, dat: d};
      do @(posedge i_clk); while (o_wb.ack !== 1'b1);
      if (!we) chk("register", {43'h0, d & m}, {43'h0, o_wb.dat & m});
      i_wb <= '0;
      @(posedge i_clk);
   endtask : rd
   task automatic load(input int nn, input int nf);
      rtlf_item_t it;
      logic [95:0] r;
      near_q = {};
      far_q = {};
      for (int i = 0; i < nn + nf; i++) begin
         r = {rnd(), rnd(), rnd()};
         it = r[75:0];
         it.far_scan = (i < 2 * nf) ? i[0] : 1'b0;
         it.longitudinal_distance = {r[7:0], i[4:0]};
         if (it.far_scan) far_q.push_back(it);
         else near_q.push_back(it);
         i_det_valid <= 1'b1;
         i_det <= it;
         do @(posedge i_clk); while (!o_det_ready);
      end
      i_det_valid <= 1'b0;
   endtask : load
   task automatic list(input int nn, input int nf, input logic qual, input logic [15:0] cnt);
      rtlf_item_t all[$];
      load(nn, nf);
      near_q.sort() with (item.longitudinal_distance);
      far_q.sort() with (item.longitudinal_distance);
      all = {near_q, far_q};
      exp_q.push_back({RTLF_ID_HEADER, 28'h0, nn[7:0], nf[7:0], cnt, RTLF_FORMAT_VER});
      foreach (all[k]) exp_q.push_back({RTLF_ID_GENERAL, 3'h0, k[7:0], all[k].longitudinal_distance,
         all[k].lateral_distance, all[k].longitudinal_rel_velocity, all[k].motion_class, 9'h100, all[k].reflectivity});
      if (qual) foreach (all[k]) exp_q.push_back({RTLF_ID_QUALITY, 51'h0, k[7:0], all[k].dist_long_rms});
      while (exp_q.size() > 0) @(posedge i_clk);
      do @(posedge i_clk); while (!o_det_ready);
   endtask : list
   always @(posedge i_clk) begin
      if (i_rst_n && o_frame_valid && i_frame_ready)
         chk("frame", (exp_q.size() > 0) ? exp_q.pop_front() : 75'h0, {o_frame.id, dec(o_frame)});
   end
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial begin
      i_clk = 1'b0;
      forever #2.5 i_clk = ~i_clk;
   end
   initial begin
      repeat (6 * P_INT) @(posedge i_clk);
      errors++;
      print_verdict();
   end
   initial begin
      {i_rst_n, i_det_valid, slow, i_wb, i_det} = '0;
      repeat (3) @(posedge i_clk);
      i_rst_n <= 1'b1;
      @(posedge i_clk);
      rd(1'b0, RTLF_ADR_CTRL, 32'h1, 32'h3);
      list(4, 3, 1'b0, 16'h0);
      rd(1'b0, RTLF_ADR_COUNTS, 32'h0304, 32'hffff);
      rd(1'b1, RTLF_ADR_CTRL, 32'h3, 32'h0);
      slow <= 1'b1;
      list(5, 2, 1'b1, 16'h1);
      slow <= 1'b0;
      rd(1'b1, RTLF_ADR_CTRL, 32'h0, 32'h0);
      load(2, 1);
      rd(1'b0, RTLF_ADR_COUNTS, 32'h30000, 32'h1ff0000);
      repeat (P_INT) @(posedge i_clk);
      rd(1'b0, RTLF_ADR_COUNTS, 32'h0, 32'h1ff0000);
      rd(1'b0, 8'h40, 32'h0, 32'hffffffff);
      rd(1'b1, RTLF_ADR_CTRL, 32'h1, 32'h0);
      list(0, 0, 1'b0, 16'h3);
      print_verdict();
   end
endmodule : testbench
